// *** hw/fsi_ctrl.sv ***
// Security, stop hold-off and reset initialization for the flash controller
`timescale 1ns/1ps
`include "fsi_consts.svh"

module fsi_ctrl (
   input  wire logic              sys_clk_i,
   input  wire logic              sys_rst_i,
   input  wire logic              clk_en_i,
   // Configuration field read port
   output logic [17:0]            cfg_addr_o,
   output logic                   cfg_rd_o,
   input  wire logic [15:0]       cfg_data_i,
   input  wire logic              cfg_valid_i,
   input  wire logic              cfg_err_i,
   input  wire logic              cfg_dbl_i,
   // Command launch and completion from the sequencer
   input  wire logic              cmd_launch_i,
   input  wire fsi_pkg::fsi_cmd_t cmd_i,
   input  wire logic [17:0]       cmd_addr_i,
   input  wire logic [63:0]       cmd_keys_i,
   input  wire logic              cmd_done_i,
   input  wire logic              erased_ok_i,
   input  wire fsi_pkg::fsi_mode_t mode_i,
   output logic                   cmd_accept_o,
   output logic                   cmd_reject_o,
   output logic                   cmd_complete_flag_o,
   // Stop handshake
   input  wire logic              stop_req_i,
   output logic                   stop_ack_o,
   // CPU access control
   output logic                   cpu_stall_o,
   output logic                   array_rd_block_o,
   // Loaded state
   output logic [7:0]             security_reg_o,
   output logic [1:0]             security_state_field_o,
   output logic [7:0]             program_array_protect_reg_o,
   output logic [7:0]             data_array_protect_reg_o,
   output logic [7:0]             option_reg_o,
   output logic [15:0]            cfg_param_o,
   output logic [1:0]             verify_error_status_o,
   output logic                   secured_o,
   output logic                   debug_enable_o
);
   import fsi_pkg::*;

   // ==========================================================
   // Init sequencer
   typedef enum logic [2:0] {
      ST_STALL, ST_RD_CFG, ST_RD_PROT, ST_RD_OPT, ST_RD_SEC, ST_RD_KEY,
      ST_RUN, ST_BUSY
   } fsi_state_t;

   fsi_state_t  state_r;
   logic [4:0]  stall_cnt_r;
   logic [1:0]  key_idx_r;
   logic        req_out_r;
   logic        init_err_r;
   logic [15:0] keys_r [0:3];
   logic        key_locked_r;
   logic        verify_run_r;
   fsi_cmd_t    cur_cmd_r;
   logic [63:0] cur_keys_r;
   logic        keys_ok;
   logic        allowed;
   logic        unsec;
   logic        sec_region;
   logic [17:0] rd_addr;
   logic        launch_ok;
   logic        init_last;
   logic        done_now;
   logic        idle_nxt;
   logic        verify_nxt;

   assign unsec = (security_reg_o[`FSI_SEC_LSB +: 2] == `FSI_SEC_UNSECURE);

   // Address of the word the current init step needs
   always_comb begin
      unique case (state_r)
         ST_RD_CFG:  rd_addr = `FSI_ADDR_CFG;
         ST_RD_PROT: rd_addr = `FSI_ADDR_PROT;
         ST_RD_OPT:  rd_addr = `FSI_ADDR_OPT;
         ST_RD_SEC:  rd_addr = `FSI_ADDR_SEC;
         ST_RD_KEY:  rd_addr = `FSI_ADDR_KEY0 + {15'h0, key_idx_r, 1'b0};
         default:    rd_addr = `FSI_ADDR_SEC;
      endcase
   end

   // Main sequence: reset restarts init and so aborts any command
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         state_r     <= ST_STALL;
         stall_cnt_r <= 5'h0;
         key_idx_r   <= 2'h0;
         req_out_r   <= 1'b0;
      end else if (clk_en_i) begin
         unique case (state_r)
            ST_STALL: begin
               if (stall_cnt_r == 5'(`FSI_STALL_CYC - 1)) begin
                  state_r <= ST_RD_CFG;
               end else begin
                  stall_cnt_r <= stall_cnt_r + 5'h1;
               end
            end
            ST_RD_CFG, ST_RD_PROT, ST_RD_OPT, ST_RD_SEC: begin
               req_out_r <= ~cfg_valid_i;
               if (cfg_valid_i && req_out_r) begin
                  req_out_r <= 1'b0;
                  unique case (state_r)
                     ST_RD_CFG:  state_r <= ST_RD_PROT;
                     ST_RD_PROT: state_r <= ST_RD_OPT;
                     ST_RD_OPT:  state_r <= ST_RD_SEC;
                     default:    state_r <= ST_RD_KEY;
                  endcase
               end
            end
            ST_RD_KEY: begin
               req_out_r <= ~cfg_valid_i;
               if (cfg_valid_i && req_out_r) begin
                  req_out_r <= 1'b0;
                  key_idx_r <= key_idx_r + 2'h1;
                  if (key_idx_r == 2'(`FSI_NKEYS - 1)) begin
                     state_r <= ST_RUN;
                  end
               end
            end
            ST_RUN: begin
               if (cmd_launch_i && allowed) begin
                  state_r <= ST_BUSY;
               end
            end
            ST_BUSY: begin
               if (cmd_done_i) begin
                  state_r <= ST_RUN;
               end
            end
         endcase
      end
   end

   // ==========================================================
   // Loaded registers; security only changes by reload or unsecure
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         security_reg_o              <= `FSI_DEF_SEC;
         program_array_protect_reg_o <= `FSI_DEF_PROT;
         data_array_protect_reg_o    <= `FSI_DEF_DPROT;
         option_reg_o                <= `FSI_DEF_OPT;
         cfg_param_o                 <= `FSI_DEF_CFG;
         init_err_r                  <= 1'b0;
         verify_error_status_o       <= 2'h0;
      end else if (clk_en_i) begin
         if (cfg_valid_i && req_out_r && !init_err_r) begin
            if (cfg_err_i) begin
               // Once wrong, stay at defaults for the rest of init
               init_err_r                  <= 1'b1;
               security_reg_o              <= `FSI_DEF_SEC;
               program_array_protect_reg_o <= `FSI_DEF_PROT;
               data_array_protect_reg_o    <= `FSI_DEF_DPROT;
               option_reg_o                <= `FSI_DEF_OPT;
               cfg_param_o                 <= `FSI_DEF_CFG;
            end else begin
               unique case (state_r)
                  ST_RD_CFG:  cfg_param_o <= cfg_data_i;
                  ST_RD_PROT: begin
                     program_array_protect_reg_o <= cfg_data_i[7:0];
                     data_array_protect_reg_o    <= cfg_data_i[15:8];
                  end
                  ST_RD_OPT:  option_reg_o <= cfg_data_i[7:0];
                  ST_RD_SEC:  security_reg_o <= cfg_data_i[7:0];
                  default:    ;
               endcase
            end
         end
         if (cfg_valid_i && req_out_r && cfg_dbl_i) begin
            verify_error_status_o <= 2'h3;
         end
         if (state_r == ST_BUSY && cmd_done_i) begin
            if (cur_cmd_r == FSI_CMD_VERIFY_KEY && keys_ok) begin
               security_reg_o[`FSI_SEC_LSB +: 2] <= `FSI_SEC_UNSECURE;
            end
            if (cur_cmd_r == FSI_CMD_ERASE_VERIFY_ALL && erased_ok_i
                && mode_i == FSI_MODE_SPECIAL) begin
               security_reg_o[`FSI_SEC_LSB +: 2] <= `FSI_SEC_UNSECURE;
            end
            if (cur_cmd_r == FSI_CMD_UNSECURE) begin
               security_reg_o[`FSI_SEC_LSB +: 2] <= `FSI_SEC_UNSECURE;
            end
         end
      end
   end

   // Keys held for comparison only; verify never writes them back
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         for (int i = 0; i < `FSI_NKEYS; i++) begin
            keys_r[i] <= `FSI_KEY_ZERO;
         end
      end else if (clk_en_i) begin
         if (state_r == ST_RD_KEY && cfg_valid_i && req_out_r) begin
            keys_r[key_idx_r] <= cfg_err_i ? `FSI_KEY_ZERO : cfg_data_i;
         end
      end
   end

   // Match needs every word equal and none of the forbidden values
   always_comb begin
      keys_ok = !init_err_r;
      for (int i = 0; i < `FSI_NKEYS; i++) begin
         if (keys_r[i] != cur_keys_r[16*i +: 16] ||
             keys_r[i] == `FSI_KEY_ZERO ||
             keys_r[i] == `FSI_KEY_ONES) begin
            keys_ok = 1'b0;
         end
      end
   end

   // ==========================================================
   // Command gating by mode and security
   assign sec_region = (cmd_addr_i[17:8] == 10'(`FSI_ADDR_SEC >> 8));

   always_comb begin
      unique case (cmd_i)
         FSI_CMD_VERIFY_KEY:
            allowed = !key_locked_r &&
               security_reg_o[`FSI_BACKDOOR_KEY_ENABLE_LSB +: 2] == `FSI_BACKDOOR_KEY_ENABLE_ON;
         FSI_CMD_ERASE_VERIFY_ALL: allowed = 1'b1;
         FSI_CMD_ERASE_ALL, FSI_CMD_UNSECURE:
            allowed = (mode_i == FSI_MODE_SPECIAL) || unsec;
         FSI_CMD_PROGRAM, FSI_CMD_ERASE_SECTOR:
            // Security sector needs unsecured device and upper unprotected
            allowed = !sec_region ||
               (unsec && program_array_protect_reg_o[7]);
         default: allowed = 1'b0;
      endcase
   end

   // ==========================================================
   // Look-ahead for the registered outputs
   // Flag moves on the very edge that launches or ends a command, read block
   // on the edge that launches or ends a key verify, the stop answer on the launch edge; read off the
   // state register alone they would trail by a cycle and leave a stop or a read open.
   // A stop raised together with a launch loses: the command is
   // already committed and must run to its end first.
   assign launch_ok = (state_r == ST_RUN) && cmd_launch_i && allowed;
   assign done_now  = (state_r == ST_BUSY) && cmd_done_i;

   // Last key word taken, so the run state starts next cycle
   assign init_last = (state_r == ST_RD_KEY) && cfg_valid_i && req_out_r
                      && key_idx_r == 2'(`FSI_NKEYS - 1);

   // Idle next cycle: nothing launched, or init or a command just ended
   assign idle_nxt = (state_r == ST_RUN && !launch_ok) || init_last
                     || done_now;

   // Key verify runs from its launch edge up to its done edge
   assign verify_nxt = (launch_ok && cmd_i == FSI_CMD_VERIFY_KEY)
                       || (verify_run_r && !done_now);

   // Command capture and lock after a bad key
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         key_locked_r <= 1'b0;
         verify_run_r <= 1'b0;
         cur_cmd_r    <= FSI_CMD_NONE;
         cur_keys_r   <= 64'h0;
         cmd_accept_o <= 1'b0;
         cmd_reject_o <= 1'b0;
      end else if (clk_en_i) begin
         cmd_accept_o <= 1'b0;
         cmd_reject_o <= 1'b0;
         if (state_r == ST_RUN && cmd_launch_i) begin
            cmd_accept_o <= allowed;
            cmd_reject_o <= ~allowed;
            if (allowed) begin
               cur_cmd_r    <= cmd_i;
               cur_keys_r   <= cmd_keys_i;
               verify_run_r <= (cmd_i == FSI_CMD_VERIFY_KEY);
            end
         end
         if (state_r == ST_BUSY && cmd_done_i) begin
            verify_run_r <= 1'b0;
            if (cur_cmd_r == FSI_CMD_VERIFY_KEY && !keys_ok) begin
               key_locked_r <= 1'b1;
            end
         end
      end
   end

   // ==========================================================
   // Registered outputs
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         cmd_complete_flag_o    <= 1'b0;
         stop_ack_o             <= 1'b0;
         cpu_stall_o            <= 1'b1;
         array_rd_block_o       <= 1'b1;
         cfg_addr_o             <= `FSI_ADDR_SEC;
         cfg_rd_o               <= 1'b0;
         security_state_field_o <= 2'(`FSI_DEF_SEC >> `FSI_SEC_LSB);
         secured_o              <= 1'b1;
         debug_enable_o         <= 1'b0;
      end else if (clk_en_i) begin
         // Flag low through init and while busy, dropped on launch edge
         cmd_complete_flag_o <= idle_nxt;
         // No ack while a command runs, so it completes first; the ack
         // needs the run state, so it comes with or after the flag and never stands with flag low
         stop_ack_o <= stop_req_i && state_r == ST_RUN
                       && !launch_ok;
         cpu_stall_o <= (state_r == ST_STALL);
         // Reads stay shut from the verify launch edge to its done edge
         array_rd_block_o <= (state_r == ST_STALL) || verify_nxt;
         cfg_addr_o <= rd_addr;
         cfg_rd_o   <= (state_r inside {ST_RD_CFG, ST_RD_PROT, ST_RD_OPT,
                        ST_RD_SEC, ST_RD_KEY}) && !cfg_valid_i;
         // Only reload or unsecure moves these, never a new program
         security_state_field_o <= security_reg_o[`FSI_SEC_LSB +: 2];
         secured_o      <= !unsec;
         debug_enable_o <= unsec;
      end
   end

endmodule // fsi_ctrl

// *** hw/fsi_consts.svh ***
// Constants for the flash security and reset-initialization block
`ifndef FSI_CONSTS_SVH
`define FSI_CONSTS_SVH

// Configuration field addresses (18-bit global)
`define FSI_ADDR_KEY0      18'h3ff00
`define FSI_ADDR_PROT      18'h3ff0c
`define FSI_ADDR_DPROT     18'h3ff0d
`define FSI_ADDR_OPT       18'h3ff0e
`define FSI_ADDR_SEC       18'h3ff0f
`define FSI_ADDR_CFG       18'h3ff08

// Security byte fields
`define FSI_SEC_LSB        0
`define FSI_BACKDOOR_KEY_ENABLE_LSB      6
`define FSI_SEC_UNSECURE   2'h2
`define FSI_BACKDOOR_KEY_ENABLE_ON       2'h2

// Built-in defaults: protected and secured
`define FSI_DEF_SEC        8'hff
`define FSI_DEF_PROT       8'h00
`define FSI_DEF_DPROT      8'h00
`define FSI_DEF_OPT        8'hff
`define FSI_DEF_CFG        16'h0000

// Forbidden key values
`define FSI_KEY_ZERO       16'h0000
`define FSI_KEY_ONES       16'hffff

// Initialization timing
`define FSI_STALL_NS       400
`define FSI_CLK_NS         40
`define FSI_STALL_CYC      ((`FSI_STALL_NS + `FSI_CLK_NS - 1) / `FSI_CLK_NS)
`define FSI_NKEYS          4

`endif

// *** hw/fsi_pkg.sv ***
// Types for the flash security and reset-initialization block
package fsi_pkg;

   // Operating modes of the surrounding chip
   typedef enum logic [1:0] {
      FSI_MODE_NORMAL,
      FSI_MODE_SPECIAL,
      FSI_MODE_OTHER
   } fsi_mode_t;

   // Commands this block decides on
   typedef enum logic [2:0] {
      FSI_CMD_NONE,
      FSI_CMD_VERIFY_KEY,
      FSI_CMD_ERASE_VERIFY_ALL,
      FSI_CMD_ERASE_ALL,
      FSI_CMD_UNSECURE,
      FSI_CMD_PROGRAM,
      FSI_CMD_ERASE_SECTOR
   } fsi_cmd_t;

endpackage

// *** bench/fsi_ctrl_assertions.sv ***
// Concurrent checks on the security and init controller ports
`timescale 1ns/1ps
module fsi_ctrl_assertions (
   input wire logic              sys_clk_i,
   input wire logic              sys_rst_i,
   input wire logic              clk_en_i,
   input wire logic              cfg_rd_o,
   input wire logic              cfg_valid_i,
   input wire logic              cfg_dbl_i,
   input wire logic              cmd_launch_i,
   input wire fsi_pkg::fsi_cmd_t cmd_i,
   input wire logic              cmd_accept_o,
   input wire logic              cmd_reject_o,
   input wire logic              cmd_complete_flag_o,
   input wire logic              stop_req_i,
   input wire logic              stop_ack_o,
   input wire logic              cpu_stall_o,
   input wire logic              array_rd_block_o,
   input wire logic [1:0]        security_state_field_o,
   input wire logic [7:0]        program_array_protect_reg_o,
   input wire logic [7:0]        data_array_protect_reg_o,
   input wire logic [1:0]        verify_error_status_o
);
   import fsi_pkg::*;
   // ====
   // One clock domain, so one default clock and reset
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (sys_rst_i);

   chk_stop_held: assert property (
      clk_en_i && !cmd_complete_flag_o |=> !stop_ack_o)
      else $error("stop granted while busy");
   chk_stop_grant: assert property (
      clk_en_i && stop_req_i && cmd_complete_flag_o && !cmd_launch_i
      |=> stop_ack_o) else $error("stop refused while idle");
   chk_stall_guard: assert property (
      cpu_stall_o |-> array_rd_block_o && !cmd_complete_flag_o)
      else $error("stall without block or with flag");
   chk_launch_answer: assert property (
      clk_en_i && cmd_launch_i && cmd_complete_flag_o
      |=> cmd_accept_o != cmd_reject_o) else $error("launch unanswered");
   chk_busy_ignored: assert property (
      clk_en_i && cmd_launch_i && !cmd_complete_flag_o
      |=> !cmd_accept_o && !cmd_reject_o) else $error("busy launch taken");
   chk_verify_blocks: assert property (
      cmd_accept_o && $past(cmd_i) == FSI_CMD_VERIFY_KEY
      |-> array_rd_block_o) else $error("reads open in verify");
   chk_prot_steady: assert property (
      cmd_complete_flag_o |=> $stable(program_array_protect_reg_o)
      && $stable(data_array_protect_reg_o)) else $error("protect moved");
   chk_sec_on_done: assert property (
      cmd_complete_flag_o && $changed(security_state_field_o)
      |-> !$past(cmd_complete_flag_o, 2)) else $error("security moved idle");
   chk_dbl_status: assert property (
      $past(cfg_rd_o) && cfg_valid_i && cfg_dbl_i
      |-> ##[1:40] verify_error_status_o == 2'h3)
      else $error("double fault unreported");
endmodule // fsi_ctrl_assertions

// *** bench/fsi_cfg_model.sv ***
// Configuration field model answering the init read requests
`timescale 1ns/1ps
`include "fsi_consts.svh"
module fsi_cfg_model (
   input  wire logic        sys_clk_i,
   input  wire logic        sys_rst_i,
   input  wire logic [17:0] addr_i,
   input  wire logic        rd_i,
   input  wire logic        slow_i,
   input  wire logic        err_i,
   input  wire logic        dbl_i,
   input  wire logic [7:0]  sec_i,
   input  wire logic [63:0] keys_i,
   output logic [15:0]      data_o,
   output logic             valid_o,
   output logic             err_o,
   output logic             dbl_o
);
   logic [15:0] word;
   logic        wait_r;
   // Stored words; prot word low byte program, high byte data
   always_comb begin
      case (addr_i)
         `FSI_ADDR_CFG:  word = 16'h1234;
         `FSI_ADDR_PROT: word = 16'h5a81;
         `FSI_ADDR_OPT:  word = 16'h00c3;
         `FSI_ADDR_SEC:  word = {8'hff, sec_i};
         default:        word = keys_i[{addr_i[2:1], 4'h0} +: 16];
      endcase
   end
   // One answer per request; idle data toggles so stale reads show
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         {wait_r, valid_o, err_o, dbl_o, data_o} <= '0;
      end else if (rd_i && !valid_o && wait_r >= slow_i) begin
         {valid_o, err_o, dbl_o, wait_r} <= {1'b1, err_i, dbl_i, 1'b0};
         data_o <= word;
      end else begin
         {valid_o, err_o, dbl_o} <= 3'h0;
         data_o <= ~data_o;
         wait_r <= rd_i && !valid_o;
      end
   end
endmodule // fsi_cfg_model

// *** bench/testbench.sv ***
// Self-checking bench for the flash security and init controller
`timescale 1ns/1ps
`include "fsi_consts.svh"
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin \
   err_total++; $display("BAD %s exp %h got %h", n, e, a); end end
module testbench;
   import fsi_pkg::*;
   // ====
   logic sys_clk_i = 0, sys_rst_i = 1, clk_en_i = 1, cmd_launch_i = 0;
   logic cmd_done_i = 0, erased_ok_i = 0, stop_req_i = 0, slow = 0;
   logic err_inj = 0, dbl_inj = 0, cfg_valid_i, cfg_err_i, cfg_dbl_i;
   logic cfg_rd_o, cmd_accept_o, cmd_reject_o, cmd_complete_flag_o;
   logic stop_ack_o, cpu_stall_o, array_rd_block_o, secured_o;
   logic debug_enable_o;
   logic [7:0] sec_b = 8'hff, security_reg_o, option_reg_o;
   logic [7:0] program_array_protect_reg_o, data_array_protect_reg_o;
   logic [63:0] keys = 64'h0, cmd_keys_i = 64'h0;
   logic [17:0] cmd_addr_i = 18'h0, cfg_addr_o;
   logic [15:0] cfg_data_i, cfg_param_o;
   logic [1:0] security_state_field_o, verify_error_status_o;
   fsi_cmd_t cmd_i = FSI_CMD_NONE;
   fsi_mode_t mode_i = FSI_MODE_NORMAL;
   int err_total = 0, samples_checked = 0, cycles = 0;
   integer seed = 19;

   fsi_ctrl u_fsi_ctrl (.sys_clk_i, .sys_rst_i, .clk_en_i, .cfg_addr_o,
      .cfg_rd_o, .cfg_data_i, .cfg_valid_i, .cfg_err_i, .cfg_dbl_i,
      .cmd_launch_i, .cmd_i, .cmd_addr_i, .cmd_keys_i, .cmd_done_i,
      .erased_ok_i, .mode_i, .cmd_accept_o, .cmd_reject_o,
      .cmd_complete_flag_o, .stop_req_i, .stop_ack_o, .cpu_stall_o,
      .array_rd_block_o, .security_reg_o, .security_state_field_o,
      .program_array_protect_reg_o, .data_array_protect_reg_o,
      .option_reg_o, .cfg_param_o, .verify_error_status_o, .secured_o,
      .debug_enable_o);
   fsi_cfg_model u_fsi_cfg_model (.sys_clk_i, .sys_rst_i,
      .addr_i(cfg_addr_o), .rd_i(cfg_rd_o), .slow_i(slow), .err_i(err_inj),
      .dbl_i(dbl_inj), .sec_i(sec_b), .keys_i(keys), .data_o(cfg_data_i),
      .valid_o(cfg_valid_i), .err_o(cfg_err_i), .dbl_o(cfg_dbl_i));

   // Clock, and a cycle ceiling far above the expected run
   initial forever #20 sys_clk_i = ~sys_clk_i;
   always @(posedge sys_clk_i) begin
      cycles++;
      if (cycles == 20000) begin err_total++; conclude(); end
   end

   // Unlock expected only with key enable on and no forbidden key
   function automatic logic key_ok(input logic [7:0] s,
                                   input logic [63:0] st, pr);
      key_ok = s[7:6] == 2'h2 && st == pr;
      for (int i = 0; i < 4; i++)
         if (st[16*i +: 16] inside {16'h0, 16'hffff}) key_ok = 0;
   endfunction

   // Reset for 20 cycles, then wait for init under a bound
   task automatic boot(input logic [7:0] s, input logic [63:0] k,
                       input logic e, d, sl, input fsi_mode_t m);
      int n;
      @(negedge sys_clk_i);
      {sec_b, keys, err_inj, dbl_inj, slow} = {s, k, e, d, sl};
      mode_i = m;
      sys_rst_i = 1;
      repeat (20) @(negedge sys_clk_i);
      sys_rst_i = 0;
      repeat (5) @(negedge sys_clk_i);
      `CHK("early stall", 1'b1, cpu_stall_o)
      `CHK("init flag", 1'b0, cmd_complete_flag_o)
      for (n = 0; n < 300 && cmd_complete_flag_o !== 1'b1; n++)
         @(negedge sys_clk_i);
      `CHK("init done", 1'b1, cmd_complete_flag_o)
      `CHK("stall off", 1'b0, cpu_stall_o)
   endtask

   // Launch at a falling edge; the sequencer finishes accepted work
   task automatic run(input fsi_cmd_t c, input logic [17:0] a,
                      input logic [63:0] k, input logic ok, output logic acc);
      cmd_i = c;
      {cmd_addr_i, cmd_keys_i, erased_ok_i} = {a, k, ok};
      cmd_launch_i = 1;
      @(negedge sys_clk_i);
      cmd_launch_i = 0;
      acc = cmd_accept_o;
      `CHK("answer", 1'b1, cmd_accept_o ^ cmd_reject_o)
      if (acc) begin
         `CHK("block", c == FSI_CMD_VERIFY_KEY, array_rd_block_o)
         @(negedge sys_clk_i);
         cmd_launch_i = 1;
         @(negedge sys_clk_i);
         cmd_launch_i = 0;
         `CHK("busy launch", 2'h0, {cmd_accept_o, cmd_reject_o})
         @(negedge sys_clk_i);
         `CHK("busy stop", 1'b0, stop_ack_o)
         cmd_done_i = 1;
         @(negedge sys_clk_i);
         cmd_done_i = 0;
         @(negedge sys_clk_i);
         `CHK("done", 1'b1, cmd_complete_flag_o)
      end else begin
         @(negedge sys_clk_i);
      end
   endtask

   task automatic conclude;
      $display("checked %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   initial begin
      logic acc;
      logic [63:0] k, kk;
      logic [7:0] s, ss;
      logic [1:0] ef;
      // Bit 0 set and bit 1 clear keeps random keys legal
      k = {$random(seed), $random(seed)};
      k = (k | 64'h0001000100010001) & ~64'h0002000200020002;
      s = 8'h80 | (8'($random(seed)) & 8'h3c);
      boot(s, k, 0, 0, 0, FSI_MODE_NORMAL);
      `CHK("sec reg", s, security_reg_o)
      `CHK("prot", 8'h81, program_array_protect_reg_o)
      `CHK("dprot", 8'h5a, data_array_protect_reg_o)
      `CHK("opt", 8'hc3, option_reg_o)
      `CHK("param", 16'h1234, cfg_param_o)
      sec_b = 8'h82;
      stop_req_i = 1;
      repeat (2) @(negedge sys_clk_i);
      `CHK("idle stop", 1'b1, stop_ack_o)
      clk_en_i = 0;
      stop_req_i = 0;
      repeat (2) @(negedge sys_clk_i);
      `CHK("frozen ack", 1'b1, stop_ack_o)
      clk_en_i = 1;
      stop_req_i = 1;
      run(FSI_CMD_ERASE_ALL, 18'h0, 0, 0, acc);
      `CHK("erase all", 1'b0, acc)
      run(FSI_CMD_VERIFY_KEY, 18'h0, ~k, 0, acc);
      `CHK("bad key acc", 1'b1, acc)
      @(negedge sys_clk_i);
      `CHK("stop after", 1'b1, stop_ack_o)
      run(FSI_CMD_VERIFY_KEY, 18'h0, k, 0, acc);
      `CHK("retry acc", 1'b0, acc)
      `CHK("sec hold", s, security_reg_o)
      // Zero key, all-ones key, key enable off, then a clean match
      for (int i = 0; i < 4; i++) begin
         kk = k;
         ss = s;
         if (i < 2) kk[15:0] = {16{i[0]}};
         if (i == 2) ss[7:6] = 2'h1;
         boot(ss, kk, 0, 0, i == 3, FSI_MODE_NORMAL);
         run(FSI_CMD_VERIFY_KEY, 18'h0, kk, 0, acc);
         ef = key_ok(ss, kk, kk) ? 2'h2 : ss[1:0];
         `CHK("verify acc", ss[7:6] == 2'h2, acc)
         `CHK("field", ef, security_state_field_o)
         `CHK("secured", ef != 2'h2, secured_o)
         `CHK("prot kept", 8'h81, program_array_protect_reg_o)
      end
      run(FSI_CMD_ERASE_SECTOR, `FSI_ADDR_SEC, 0, 0, acc);
      `CHK("sector acc", 1'b1, acc)
      run(FSI_CMD_PROGRAM, `FSI_ADDR_SEC, 0, 0, acc);
      `CHK("sec prog", 1'b1, acc)
      // Reset lands while a matching verify is running
      boot(s, k, 0, 0, 0, FSI_MODE_NORMAL);
      cmd_i = FSI_CMD_VERIFY_KEY;
      {cmd_keys_i, cmd_launch_i} = {k, 1'b1};
      @(negedge sys_clk_i);
      cmd_launch_i = 0;
      boot(s, k, 0, 0, 0, FSI_MODE_NORMAL);
      `CHK("aborted", s[1:0], security_state_field_o)
      `CHK("abort block", 1'b0, array_rd_block_o)
      // Debug-port unlock: verify, erase, unsecure, reset, verify again
      boot(s, k, 0, 0, 0, FSI_MODE_SPECIAL);
      run(FSI_CMD_ERASE_VERIFY_ALL, 18'h0, 0, 0, acc);
      `CHK("not erased", 1'b1, secured_o)
      run(FSI_CMD_ERASE_ALL, 18'h0, 0, 0, acc);
      `CHK("erase all sp", 1'b1, acc)
      run(FSI_CMD_UNSECURE, 18'h0, 0, 0, acc);
      `CHK("unsecure sp", 1'b1, acc)
      `CHK("unsec cmd", 1'b0, secured_o)
      boot(8'hff, '1, 0, 0, 1, FSI_MODE_SPECIAL);
      run(FSI_CMD_ERASE_VERIFY_ALL, 18'h0, 0, 1, acc);
      `CHK("unsecured", 1'b0, secured_o)
      `CHK("debug on", 1'b1, debug_enable_o)
      // Faulty field reads fall back to locked defaults
      boot(s, k, 1, 1, 0, FSI_MODE_OTHER);
      `CHK("def sec", `FSI_DEF_SEC, security_reg_o)
      `CHK("def prot", `FSI_DEF_PROT, program_array_protect_reg_o)
      `CHK("def dprot", `FSI_DEF_DPROT, data_array_protect_reg_o)
      `CHK("def opt", `FSI_DEF_OPT, option_reg_o)
      `CHK("locked", 1'b1, secured_o)
      `CHK("dbl stat", 2'h3, verify_error_status_o)
      conclude();
   end
endmodule // testbench

bind fsi_ctrl fsi_ctrl_assertions u_fsi_ctrl_assertions (.sys_clk_i,
   .sys_rst_i, .clk_en_i, .cfg_rd_o, .cfg_valid_i, .cfg_dbl_i,
   .cmd_launch_i, .cmd_i, .cmd_accept_o, .cmd_reject_o,
   .cmd_complete_flag_o, .stop_req_i, .stop_ack_o, .cpu_stall_o,
   .array_rd_block_o, .security_state_field_o,
   .program_array_protect_reg_o, .data_array_protect_reg_o,
   .verify_error_status_o);
